/* src/gain_scale.v */
// Purpose: scale a magnitude by gain / 2^SHIFT (1/128 steps by default), saturating
// Assumes: unsigned inputs, combinational use
// Notes:   result = value * gain >> SHIFT
`timescale 1ns/1ps
`include "regen_defs.vh"

module gain_scale #(
    parameter W     = 16,
    parameter SHIFT = `GAIN_SHIFT
) (
    // operands
    input  wire [W-1:0] value,
    input  wire [7:0]   gain,
    // result
    output wire [W-1:0] scaled
);

    // ----------------------------------------------------------------
    // product and saturation
    // ----------------------------------------------------------------
    wire [W+7:0] prod;
    wire [W+7:0] shifted;

    // full-width product, then drop fraction
    assign prod    = value * gain;
    assign shifted = prod >> SHIFT;
    // saturate instead of wrapping
    assign scaled  = (|shifted[W+7:W]) ? {W{1'b1}} : shifted[W-1:0];

endmodule

/* src/regen_avoidance_freq_control.v */
// Purpose: raise output frequency while the dc bus is regenerating
// Assumes: all inputs come from logic on sys_clk, ctrl_tick one pulse per cycle
// Notes:   voltage in volts, frequency in 0.01 Hz, gains in 1/128 steps
//
// Summary of operation
// - mode off, always, or constant speed only
// - raise frequency when bus voltage reaches level
// - level 300 to 800 V, class default
// - cap at pre-avoidance frequency plus limit
// - limit 0 to 10 Hz, 9999 unlimited
// - decel hold limit until half limit
// - never exceed maximum output frequency
// - voltage gain 0 to 200, default 100
// - increase depends on regenerated amount
// - ramp follows regenerative load while acting
// - acting shows stall indication and overload
// - acting also enables stall prevention
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "regen_defs.vh"

module regen_avoidance_freq_control #(
    parameter HIGH_VOLT_CLASS = 0
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // drive side
    input  wire [9:0]  bus_voltage,
    input  wire [15:0] freq_cmd,
    input  wire        accel,
    input  wire        decel,
    input  wire        ctrl_tick,
    // results
    output reg  [15:0] freq_out,
    output reg         regen_active,
    output reg         ov_stall_ind,
    output reg         overload_warning_out,
    output reg         stall_prevent_en,
    output reg         irq
);

    // ----------------------------------------------------------------
    // states and constants
    // ----------------------------------------------------------------
    localparam [2:0] S_IDLE  = 3'h1;
    localparam [2:0] S_AVOID = 3'h2;
    localparam [2:0] S_HOLD  = 3'h4;
    localparam [9:0] LEVEL_RST = HIGH_VOLT_CLASS ? `LEVEL_RST_HIGH : `LEVEL_RST_LOW;

    // clamp a written word into a range
    function [15:0] clamp16;
        input [31:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v < {16'h0000, lo})
                clamp16 = lo;
            else if (v > {16'h0000, hi})
                clamp16 = hi;
            else
                clamp16 = v[15:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [1:0]           mode_reg;
    reg  [9:0]           level_reg;
    reg  [15:0]          limit_reg;
    reg  [7:0]           vgain_reg;
    reg  [7:0]           fgain_reg;
    reg  [15:0]          maxf_reg;
    reg  [`ST_WIDTH-1:0] status_reg;
    reg  [`ST_WIDTH-1:0] mask_reg;
    reg  [15:0]          comp_reg;
    reg  [15:0]          base_reg;
    reg  [15:0]          hold_reg;
    reg  [9:0]           prev_v_reg;
    reg  [2:0]           state_reg;

    reg  [2:0]           state_next;
    reg  [15:0]          comp_next;
    reg  [15:0]          base_next;
    reg  [15:0]          hold_next;
    reg  [`ST_WIDTH-1:0] event_next;
    reg  [`ST_WIDTH-1:0] status_next;
    reg  [17:0]          comp_raw;
    reg  [17:0]          sum;
    reg  [17:0]          sum_lim;
    reg  [17:0]          out_calc;
    reg  [31:0]          rd_mux;

    wire                 enabled;
    wire                 over;
    wire [9:0]           err;
    wire [9:0]           dv;
    wire [15:0]          v_step;
    wire [15:0]          f_step;
    wire [17:0]          step_sum;
    wire [17:0]          cap;
    wire                 limit_on;
    wire                 acting;
    wire                 wr_status;
    wire [15:0]          level_wr = clamp16(reg_wdata, `LEVEL_MIN, `LEVEL_MAX);
    wire [15:0]          gain_wr  = clamp16(reg_wdata, 16'h0000, `GAIN_MAX);

    // ----------------------------------------------------------------
    // detection
    // ----------------------------------------------------------------
    // mode gating: constant speed means neither ramp flag set
    assign enabled  = (mode_reg == `MODE_ALWAYS) |
                      ((mode_reg == `MODE_CONST) & ~accel & ~decel);
    assign over     = enabled & (bus_voltage >= level_reg);
    assign err      = over ? (bus_voltage - level_reg) : 10'h000;
    // rising bus voltage feeds the frequency gain term
    assign dv       = (over && bus_voltage > prev_v_reg) ?
                      (bus_voltage - prev_v_reg) : 10'h000;
    assign step_sum = {2'b00, v_step} + {2'b00, f_step};
    assign limit_on = (limit_reg != `LIMIT_OFF);
    // base is the present command until avoidance latches it
    assign cap      = {2'b00, (state_reg == S_IDLE) ? freq_cmd : base_reg} +
                      {2'b00, limit_reg};
    assign acting   = (state_next != S_IDLE);
    assign wr_status = reg_wr & (reg_addr == `ADDR_STATUS);

    // step proportional to overshoot above level
    gain_scale #(.W(16), .SHIFT(`GAIN_SHIFT)) u_vscale (
        .value  ({6'h00, err}),
        .gain   (vgain_reg),
        .scaled (v_step)
    );

    // step proportional to rate of bus rise
    gain_scale #(.W(16), .SHIFT(`GAIN_SHIFT)) u_fscale (
        .value  ({6'h00, dv}),
        .gain   (fgain_reg),
        .scaled (f_step)
    );

    // ----------------------------------------------------------------
    // compensation and state
    // ----------------------------------------------------------------
    // new compensation, capped by limit and maximum frequency
    always @* begin
        if (over)
            comp_raw = {2'b00, comp_reg} + step_sum;
        else if (comp_reg > `DECAY_STEP)
            comp_raw = {2'b00, comp_reg - `DECAY_STEP};
        else
            comp_raw = 18'h00000;
        sum = {2'b00, freq_cmd} + comp_raw;
        sum_lim = sum;
        if (limit_on && !decel && sum > cap)
            sum_lim = cap;
        if (sum_lim > {2'b00, maxf_reg})
            sum_lim = {2'b00, maxf_reg};
        if (sum_lim < {2'b00, freq_cmd})
            sum_lim = {2'b00, freq_cmd};
    end

    // state machine, advanced on the control tick, except that mode off forces idle at once
    always @* begin
        state_next = state_reg;
        comp_next  = comp_reg;
        base_next  = base_reg;
        hold_next  = hold_reg;
        event_next = {`ST_WIDTH{1'b0}};
        if (mode_reg == `MODE_OFF) begin
            state_next = S_IDLE;
            comp_next  = 16'h0000;
        end else if (ctrl_tick) begin
            case (state_reg)
                S_IDLE: begin
                    if (over) begin
                        state_next = S_AVOID;
                        base_next  = freq_cmd;
                        comp_next  = sum_lim[15:0] - freq_cmd;
                        event_next[`ST_START] = 1'b1;
                    end
                end
                S_AVOID: begin
                    if (decel && limit_on && sum > cap) begin
                        state_next = S_HOLD;
                        hold_next  = (cap > {2'b00, maxf_reg}) ?
                                     maxf_reg : cap[15:0];
                        comp_next  = 16'h0000;
                        event_next[`ST_HOLD] = 1'b1;
                    end else begin
                        comp_next = sum_lim[15:0] - freq_cmd;
                        if (comp_next == 16'h0000 && !over)
                            state_next = S_IDLE;
                    end
                    if (sum > {2'b00, maxf_reg})
                        event_next[`ST_MAXF] = 1'b1;
                end
                S_HOLD: begin
                    if ({freq_cmd, 1'b0} <= {1'b0, limit_reg})
                        state_next = S_IDLE;
                end
                default: begin
                    state_next = S_IDLE;
                    comp_next  = 16'h0000;
                end
            endcase
        end
    end

    // output frequency for the present state
    always @* begin
        case (state_reg)
            S_AVOID: out_calc = {2'b00, freq_cmd} + {2'b00, comp_reg};
            S_HOLD:  out_calc = {2'b00, hold_reg};
            default: out_calc = {2'b00, freq_cmd};
        endcase
        if (out_calc > {2'b00, maxf_reg})
            out_calc = {2'b00, maxf_reg};
    end

    // sticky status, a new event beats a clear in the same cycle
    always @* begin
        status_next = status_reg & ~(wr_status ? reg_wdata[`ST_WIDTH-1:0]
                                               : {`ST_WIDTH{1'b0}});
        status_next = status_next | event_next;
    end

    // read multiplexer
    always @* begin
        case (reg_addr)
            `ADDR_MODE:   rd_mux = {30'h0, mode_reg};
            `ADDR_LEVEL:  rd_mux = {22'h0, level_reg};
            `ADDR_LIMIT:  rd_mux = {16'h0, limit_reg};
            `ADDR_VGAIN:  rd_mux = {24'h0, vgain_reg};
            `ADDR_FGAIN:  rd_mux = {24'h0, fgain_reg};
            `ADDR_MAXF:   rd_mux = {16'h0, maxf_reg};
            `ADDR_STATUS: rd_mux = {29'h0, status_reg};
            `ADDR_MASK:   rd_mux = {29'h0, mask_reg};
            `ADDR_COMP:   rd_mux = {16'h0, comp_reg};
            `ADDR_STATE:  rd_mux = {29'h0, state_reg};
            default:      rd_mux = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // settings written by software
    // ----------------------------------------------------------------
    // level, limit and gain writes are clamped into their legal ranges; mode ignores codes above 2
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            mode_reg  <= `MODE_OFF;
            level_reg <= LEVEL_RST;
            limit_reg <= `LIMIT_RST;
            vgain_reg <= `VGAIN_RST;
            fgain_reg <= `FGAIN_RST;
            maxf_reg  <= `MAXF_RST;
            mask_reg  <= {`ST_WIDTH{1'b0}};
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_MODE: begin
                    if (reg_wdata < 32'h00000003)
                        mode_reg <= reg_wdata[1:0];
                end
                `ADDR_LEVEL: begin
                    level_reg <= level_wr[9:0];
                end
                `ADDR_LIMIT: begin
                    if (reg_wdata == {16'h0000, `LIMIT_OFF})
                        limit_reg <= `LIMIT_OFF;
                    else
                        limit_reg <= clamp16(reg_wdata, 16'h0000, `LIMIT_MAX);
                end
                `ADDR_VGAIN: begin
                    vgain_reg <= gain_wr[7:0];
                end
                `ADDR_FGAIN: begin
                    fgain_reg <= gain_wr[7:0];
                end
                `ADDR_MAXF: begin
                    maxf_reg <= reg_wdata[15:0];
                end
                `ADDR_MASK: begin
                    mask_reg <= reg_wdata[`ST_WIDTH-1:0];
                end
                default: begin
                    mask_reg <= mask_reg;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // control state and outputs
    // ----------------------------------------------------------------
    // every output leaves from a flip-flop
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg            <= S_IDLE;
            comp_reg             <= 16'h0000;
            base_reg             <= 16'h0000;
            hold_reg             <= 16'h0000;
            prev_v_reg           <= 10'h000;
            status_reg           <= {`ST_WIDTH{1'b0}};
            reg_rdata            <= 32'h00000000;
            freq_out             <= 16'h0000;
            regen_active         <= 1'b0;
            ov_stall_ind         <= 1'b0;
            overload_warning_out <= 1'b0;
            stall_prevent_en     <= 1'b0;
            irq                  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            comp_reg   <= comp_next;
            base_reg   <= base_next;
            hold_reg   <= hold_next;
            status_reg <= status_next;
            if (ctrl_tick)
                prev_v_reg <= bus_voltage;
            reg_rdata            <= reg_rd ? rd_mux : 32'h00000000;
            freq_out             <= out_calc[15:0];
            regen_active         <= acting;
            ov_stall_ind         <= acting;
            overload_warning_out <= acting;
            stall_prevent_en     <= acting;
            irq                  <= |(status_next & mask_reg);
        end
    end

endmodule

/* src/regen_defs.vh */
// Purpose: constants shared by the regeneration-avoidance control block
// Assumes: voltages in volts, frequencies in 0.01 Hz steps, gains in 1/128 steps
// Notes:   byte addresses of the plain register port
`ifndef REGEN_DEFS_VH
`define REGEN_DEFS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_MODE       8'h00
`define ADDR_LEVEL      8'h04
`define ADDR_LIMIT      8'h08
`define ADDR_VGAIN      8'h0c
`define ADDR_FGAIN      8'h10
`define ADDR_MAXF       8'h14
`define ADDR_STATUS     8'h18
`define ADDR_MASK       8'h1c
`define ADDR_COMP       8'h20
`define ADDR_STATE      8'h24

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define MODE_OFF        2'h0
`define MODE_ALWAYS     2'h1
`define MODE_CONST      2'h2

// ----------------------------------------------------------------
// ranges and reset values
// ----------------------------------------------------------------
`define LEVEL_MIN       16'h012c
`define LEVEL_MAX       16'h0320
`define LEVEL_RST_LOW   10'h190
`define LEVEL_RST_HIGH  10'h30c
`define LIMIT_MAX       16'h03e8
`define LIMIT_RST       16'h0258
`define LIMIT_OFF       16'h270f
`define GAIN_MAX        16'h00c8
`define VGAIN_RST       8'h64
`define FGAIN_RST       8'h00
`define MAXF_RST        16'h2ee0
`define DECAY_STEP      16'h0001
`define GAIN_SHIFT      7

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define ST_START        0
`define ST_HOLD         1
`define ST_MAXF         2
`define ST_WIDTH        3

`endif

/* testbench/drive_stage_model.sv */
// Purpose: inverter ramp and bus voltage measurement beside the block
// Assumes: bench sets target frequency, ramp step and bus voltage
// Notes:   control tick every TICK_DIV clocks
`timescale 1ns/1ps
module drive_stage_model #(
    parameter TICK_DIV = 4
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset_n,
    // bench settings
    input  wire [15:0] target_freq,
    input  wire [15:0] ramp_step,
    input  wire [9:0]  volt_set,
    // toward the block
    output reg  [15:0] freq_cmd,
    output reg         accel,
    output reg         decel,
    output wire [9:0]  bus_voltage,
    output reg         ctrl_tick
);
    reg [3:0] div_reg;
    // measured bus follows the bench's operating point
    assign bus_voltage = volt_set;
    // tick divider and ramp toward the target, one step per tick
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            div_reg   <= 4'h0;
            ctrl_tick <= 1'b0;
            freq_cmd  <= 16'h0;
            accel     <= 1'b0;
            decel     <= 1'b0;
        end else begin
            div_reg   <= (div_reg == TICK_DIV - 1) ? 4'h0 : div_reg + 4'h1;
            ctrl_tick <= (div_reg == TICK_DIV - 1);
            accel     <= freq_cmd < target_freq;
            decel     <= freq_cmd > target_freq;
            if (ctrl_tick && freq_cmd < target_freq)
                freq_cmd <= (target_freq - freq_cmd > ramp_step) ? freq_cmd + ramp_step : target_freq;
            else if (ctrl_tick && freq_cmd > target_freq)
                freq_cmd <= (freq_cmd - target_freq > ramp_step) ? freq_cmd - ramp_step : target_freq;
        end
    end
endmodule

/* testbench/regen_avoidance_freq_control_asserts.sv */
// Purpose: port-level checks for the regeneration-avoidance block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto every instance of the block
`timescale 1ns/1ps
module regen_asserts (
    // clock and reset
    input wire        sys_clk,
    input wire        reset_n,
    // register port
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // drive side
    input wire [9:0]  bus_voltage,
    input wire [15:0] freq_cmd,
    input wire        accel,
    input wire        decel,
    input wire        ctrl_tick,
    // results
    input wire [15:0] freq_out,
    input wire        regen_active,
    input wire        ov_stall_ind,
    input wire        overload_warning_out,
    input wire        stall_prevent_en
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // two idle samples: no compensation can reach the output
    sequence s_quiet;
        !regen_active [*2];
    endsequence
    // tick at constant speed with the bus at or above any legal level
    sequence s_hard_regen;
        regen_active && ctrl_tick && !reg_wr && !accel && !decel && bus_voltage >= 10'h320;
    endsequence
    property p_ind_ov;
        regen_active == ov_stall_ind;
    endproperty
    a_ind_ov: assert property (p_ind_ov) else $error("stall indication off");
    property p_ind_ol;
        regen_active == overload_warning_out;
    endproperty
    a_ind_ol: assert property (p_ind_ol) else $error("overload warning off");
    property p_ind_sp;
        regen_active == stall_prevent_en;
    endproperty
    a_ind_sp: assert property (p_ind_sp) else $error("stall prevention off");
    property p_start;
        $rose(regen_active) |-> $past(ctrl_tick) && $past(bus_voltage) >= 10'h12c;
    endproperty
    a_start: assert property (p_start) else $error("start without tick or voltage");
    property p_stay;
        s_hard_regen |=> regen_active;
    endproperty
    a_stay: assert property (p_stay) else $error("dropped out under regeneration");
    property p_fall;
        $fell(regen_active) |-> $past(ctrl_tick) || $past(reg_wr) || $past(reg_wr, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("ended between ticks");
    property p_idle;
        s_quiet |-> freq_out <= $past(freq_cmd);
    endproperty
    a_idle: assert property (p_idle) else $error("idle output above command");
    property p_rd;
        reg_rdata != 32'h0 |-> $past(reg_rd);
    endproperty
    a_rd: assert property (p_rd) else $error("read data outside its cycle");
endmodule

bind regen_avoidance_freq_control regen_asserts chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_voltage(bus_voltage), .freq_cmd(freq_cmd), .accel(accel),
    .decel(decel), .ctrl_tick(ctrl_tick), .freq_out(freq_out), .regen_active(regen_active),
    .ov_stall_ind(ov_stall_ind), .overload_warning_out(overload_warning_out),
    .stall_prevent_en(stall_prevent_en)
);

/* testbench/test_regen_avoidance_freq_control.sv */
// Purpose: self-checking bench for the regeneration-avoidance block
// Assumes: partner model supplies bus voltage, ramp and control tick
// Notes:   expectations in volts, 0.01 Hz and gain steps of 1/128
`timescale 1ns/1ps
`include "regen_defs.vh"
module test_regen_avoidance_freq_control;
    reg         sys_clk;
    reg         reset_n;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire [31:0] reg_rdata;
    reg  [15:0] target_freq;
    reg  [15:0] ramp_step;
    reg  [9:0]  volt_set;
    wire [9:0]  bus_voltage;
    wire [15:0] freq_cmd;
    wire        accel;
    wire        decel;
    wire        ctrl_tick;
    wire [15:0] freq_out;
    wire        regen_active;
    wire        ov_stall_ind;
    wire        overload_warning_out;
    wire        stall_prevent_en;
    wire        irq;
    integer     err_count;
    integer     num_checks;
    integer     cycles;
    // block and its drive stage
    regen_avoidance_freq_control #(.HIGH_VOLT_CLASS(0)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_voltage(bus_voltage),
        .freq_cmd(freq_cmd), .accel(accel), .decel(decel), .ctrl_tick(ctrl_tick),
        .freq_out(freq_out), .regen_active(regen_active), .ov_stall_ind(ov_stall_ind),
        .overload_warning_out(overload_warning_out), .stall_prevent_en(stall_prevent_en),
        .irq(irq));
    drive_stage_model stage (
        .sys_clk(sys_clk), .reset_n(reset_n), .target_freq(target_freq),
        .ramp_step(ramp_step), .volt_set(volt_set), .freq_cmd(freq_cmd), .accel(accel),
        .decel(decel), .bus_voltage(bus_voltage), .ctrl_tick(ctrl_tick));
    // shared bus cycles, waits and comparison
    task check(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'b1;
            @(posedge sys_clk);
            reg_wr    <= 1'b0;
        end
    endtask
    task rd_check(input [7:0] a, input [31:0] e);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd   <= 1'b1;
            @(posedge sys_clk);
            reg_rd   <= 1'b0;
            #1;
            check(reg_rdata, e);
        end
    endtask
    task wr_rd(input [7:0] a, input [31:0] d, input [31:0] e);
        begin
            wr(a, d);
            rd_check(a, e);
        end
    endtask
    task set_in(input [9:0] v, input [15:0] f);
        begin
            @(posedge sys_clk);
            volt_set    <= v;
            target_freq <= f;
        end
    endtask
    task ticks(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge sys_clk);
                while (ctrl_tick !== 1'b1)
                    @(posedge sys_clk);
            end
            repeat (2) @(posedge sys_clk);
            #1;
        end
    endtask
    task settle;
        integer n;
        begin
            n = 0;
            while (regen_active !== 1'b0 && n < 4000) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            ticks(1);
        end
    endtask
    task test_done;
        begin
            if (err_count == 0 && num_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // scenarios
    task t_regs;
        begin
            rd_check(`ADDR_MODE, 32'h0);
            rd_check(`ADDR_LEVEL, 32'h190);
            rd_check(`ADDR_LIMIT, 32'h258);
            rd_check(`ADDR_VGAIN, 32'h64);
            rd_check(`ADDR_FGAIN, 32'h0);
            rd_check(`ADDR_MAXF, 32'h2ee0);
            wr_rd(`ADDR_STATE, 32'h4, 32'h1);
            wr_rd(8'h28, 32'h5, 32'h0);
            wr_rd(`ADDR_LEVEL, 32'h64, 32'h12c);
            wr_rd(`ADDR_LEVEL, 32'h384, 32'h320);
            wr_rd(`ADDR_LIMIT, 32'h7d0, 32'h3e8);
            wr_rd(`ADDR_LIMIT, 32'h270f, 32'h270f);
            wr_rd(`ADDR_VGAIN, 32'hfa, 32'hc8);
            wr_rd(`ADDR_FGAIN, 32'hc9, 32'hc8);
            wr_rd(`ADDR_MODE, 32'h2, 32'h2);
            wr_rd(`ADDR_MODE, 32'h3, 32'h2);
            wr(`ADDR_MODE, 32'h0);
            wr(`ADDR_LEVEL, 32'h190);
            wr(`ADDR_LIMIT, 32'h258);
            wr(`ADDR_VGAIN, 32'h64);
            wr(`ADDR_FGAIN, 32'h0);
        end
    endtask
    task t_avoid;
        begin
            set_in(10'h1f4, 16'h1388);
            ticks(3);
            check({regen_active, freq_out}, {1'b0, 16'h1388});
            wr(`ADDR_MASK, 32'h1);
            wr(`ADDR_MODE, 32'h1);
            ticks(1);
            check(freq_out, 16'h13d6);
            check({ov_stall_ind, overload_warning_out, stall_prevent_en}, 3'h7);
            check(irq, 1'b1);
            rd_check(`ADDR_STATUS, 32'h1);
            ticks(8);
            check(freq_out, 16'h15e0);
            set_in(10'h186, 16'h1388);
            ticks(1);
            check(freq_out, 16'h15df);
            settle;
            check({regen_active, freq_out}, {1'b0, 16'h1388});
            wr(`ADDR_STATUS, 32'h7);
            @(posedge sys_clk);
            #1;
            check(irq, 1'b0);
        end
    endtask
    task t_edge;
        begin
            set_in(10'h18f, 16'h1388);
            ticks(2);
            check(regen_active, 1'b0);
            set_in(10'h190, 16'h1388);
            ticks(1);
            check(regen_active, 1'b1);
            set_in(10'h18f, 16'h1388);
            ticks(2);
            check(regen_active, 1'b0);
        end
    endtask
    task t_maxf;
        begin
            wr(`ADDR_STATUS, 32'h7);
            wr(`ADDR_MAXF, 32'h13ba);
            set_in(10'h1f4, 16'h1388);
            ticks(2);
            check(freq_out, 16'h13ba);
            rd_check(`ADDR_STATUS, 32'h5);
            set_in(10'h186, 16'h1388);
            settle;
            wr(`ADDR_MAXF, 32'h2ee0);
        end
    endtask
    task t_decel;
        begin
            wr(`ADDR_LEVEL, 32'h12c);
            wr(`ADDR_VGAIN, 32'hc8);
            set_in(10'h320, 16'h1388);
            ticks(1);
            check(freq_out, 16'h15e0);
            @(posedge sys_clk);
            ramp_step <= 16'h64;
            set_in(10'h320, 16'hc8);
            ticks(20);
            check(freq_out, 16'h15e0);
            set_in(10'h12b, 16'hc8);
            ticks(10);
            check(freq_out, 16'h15e0);
            ticks(24);
            check({regen_active, freq_out}, {1'b0, 16'hc8});
            wr(`ADDR_LEVEL, 32'h190);
            wr(`ADDR_VGAIN, 32'h64);
        end
    endtask
    task t_const;
        begin
            wr(`ADDR_MODE, 32'h2);
            set_in(10'h12b, 16'h4b0);
            set_in(10'h1f4, 16'h4b0);
            ticks(3);
            check(regen_active, 1'b0);
            ticks(10);
            check(regen_active, 1'b1);
            set_in(10'h186, 16'h4b0);
            settle;
            check(regen_active, 1'b0);
        end
    endtask
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // cycle ceiling against a hung wait
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: run exceeded its cycle budget", $time);
            test_done;
        end
    end
    // reset, then the scenarios in turn
    initial begin
        err_count   = 0;
        num_checks  = 0;
        cycles      = 0;
        reset_n     = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 32'h0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        target_freq = 16'h1388;
        ramp_step   = 16'h1388;
        volt_set    = 10'h0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_regs;
        t_avoid;
        t_edge;
        t_maxf;
        t_decel;
        t_const;
        test_done;
    end
endmodule
